/* File: hw/acs_defines.vh */
// Shared constants of the conversion sequencer
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
`define ACS_ADDR_CTRL      8'h00
`define ACS_ADDR_ACQ1      8'h04
`define ACS_ADDR_ACQ5      8'h14
`define ACS_ADDR_STATUS    8'h18
`define ACS_ADDR_RESULT    8'h1c
`define ACS_ADDR_LEN       8'h20
`define ACS_CTRL_START     0
`define ACS_CTRL_CONT      1
`define ACS_CTRL_SLEEP     2
`define ACS_CTRL_SWRST     3
`define ACS_CTRL_BYPASS    4
`define ACS_ACQ1_OSR_LSB   0
`define ACS_ACQ1_NEL_LSB   3
`define ACS_ACQ1_GBIAS_LSB 5
`define ACS_ACQ1_CBIAS_LSB 7
`define ACS_OSR_CODE_MAX   3'h7
`define ACS_OSR_LOG_BASE   4'h3
`define ACS_STARTUP_US     800
`define ACS_RC_WAKE_US     450
`define ACS_CLK_MHZ        200
`define ACS_RESP_OKAY      2'h0
`define ACS_RESP_SLVERR    2'h2
`define ACS_PWR_SLEEP      2'h0
`define ACS_PWR_WAKE       2'h1
`define ACS_PWR_STARTUP    2'h2
`define ACS_PWR_ACTIVE     2'h3
`define ACS_BIAS_NOMINAL   2'h3
`endif

/* File: hw/acs_timer.v */
// Down counter that times a wait and reports its expiry
`timescale 1ns/1ps
module acs_timer #(
  parameter WIDTH = 20
) (
  input  wire             clock,
  input  wire             arst_n,
  input  wire             load,
  input  wire [WIDTH-1:0] load_value,
  output reg              busy,
  output reg              expired
);
  reg [WIDTH-1:0] count;

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count   <= {WIDTH{1'b0}};
      busy    <= 1'b0;
      expired <= 1'b0;
    end
    else if (load)
    begin
      count   <= load_value;
      busy    <= 1'b1;
      expired <= 1'b0;
    end
    else if (busy)
    begin
      count   <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      expired <= (count == {{(WIDTH-1){1'b0}}, 1'b1});
      busy    <= (count != {{(WIDTH-1){1'b0}}, 1'b1});
    end
    else
      expired <= 1'b0;
  end
endmodule

/* File: hw/acs_sequencer.v */
// Conversion sequencer with its AXI4-Lite register slave
`timescale 1ns/1ps
`include "acs_defines.vh"

module acs_sequencer #(
  parameter STARTUP_CYCLES = (`ACS_STARTUP_US * `ACS_CLK_MHZ),
  parameter WAKE_CYCLES    = (`ACS_RC_WAKE_US * `ACS_CLK_MHZ),
  parameter RES_W          = 16
) (
  input  wire             clock,
  input  wire             arst_n,
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [7:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  input  wire [RES_W-1:0] sample_data,
  output reg              gain_stage_reset,
  output reg  [1:0]       gain_stage_bias_select,
  output reg  [1:0]       converter_bias_select,
  output reg              conversion_done
);
  // ***************************************************
  // Helpers
  // ***************************************************
  function [10:0] osr_of;
    input [2:0] code;
    begin
      osr_of = 11'h008 << code;
    end
  endfunction

  function [3:0] nel_of;
    input [1:0] code;
    begin
      nel_of = 4'h1 << code;
    end
  endfunction

  // ***************************************************
  // Registers
  // ***************************************************
  reg [7:0]  acq_cfg [0:4];
  reg        cont_mode;
  reg        bypass;
  reg [1:0]  pwr_state;
  reg        converting;
  reg [14:0] conv_count;
  reg [RES_W-1:0] result;
  reg [7:0]  aw_addr;
  reg        aw_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg        w_held;
  reg        swrst_req;
  reg        start_req;
  integer    i;

  wire [2:0]  osr_code = acq_cfg[0][`ACS_ACQ1_OSR_LSB +: 3];
  wire [1:0]  nel_code = acq_cfg[0][`ACS_ACQ1_NEL_LSB +: 2];
  wire [10:0] osr = osr_of(osr_code);
  wire [3:0]  nel = nel_of(nel_code);
  wire [4:0]  twice_log = {(`ACS_OSR_LOG_BASE + {1'b0, osr_code}), 1'b0};
  wire [4:0]  resolution = twice_log + {3'h0, nel_code};
  wire [4:0]  eff_res = (resolution > RES_W[4:0]) ? RES_W[4:0] : resolution;
  wire [14:0] conv_len = nel * ({4'h0, osr} + 15'h0001) + 15'h0001;

  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire wr_ctrl = wr_go && aw_addr == `ACS_ADDR_CTRL;
  wire wr_acq = wr_go && aw_addr >= `ACS_ADDR_ACQ1 &&
                aw_addr <= `ACS_ADDR_ACQ5 && aw_addr[1:0] == 2'h0;
  wire [2:0] acq_idx = aw_addr[4:2] - 3'h1;
  wire active = (pwr_state == `ACS_PWR_ACTIVE);

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // ***************************************************
  // Power sequencing
  // ***************************************************
  wire        tmr_expired;
  reg         tmr_load;
  reg  [19:0] tmr_value;
  acs_timer #(.WIDTH(20)) u_timer (
    .clock      (clock),
    .arst_n     (arst_n),
    .load       (tmr_load),
    .load_value (tmr_value),
    .busy       (),
    .expired    (tmr_expired)
  );

  wire bus_access = wr_go || (s_axi_arvalid && s_axi_arready);

  always @*
  begin
    tmr_load  = 1'b0;
    tmr_value = WAKE_CYCLES[19:0];
    if (swrst_req || (pwr_state == `ACS_PWR_WAKE && tmr_expired))
    begin
      tmr_load  = 1'b1;
      tmr_value = STARTUP_CYCLES[19:0];
    end
    else if (pwr_state == `ACS_PWR_SLEEP && bus_access)
      tmr_load = 1'b1;
  end

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      pwr_state <= `ACS_PWR_SLEEP;
    else
    begin
      if (swrst_req)
        pwr_state <= `ACS_PWR_STARTUP;
      else case (pwr_state)
        `ACS_PWR_SLEEP:
          if (bus_access)
            pwr_state <= `ACS_PWR_WAKE;
        `ACS_PWR_WAKE:
          if (tmr_expired)
            pwr_state <= `ACS_PWR_STARTUP;
        `ACS_PWR_STARTUP:
          if (tmr_expired)
            pwr_state <= `ACS_PWR_ACTIVE;
        default:
          if (wr_ctrl && w_data[`ACS_CTRL_SLEEP])
            pwr_state <= `ACS_PWR_SLEEP;
      endcase
    end
  end

  // ***************************************************
  // Register writes
  // ***************************************************
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (i = 0; i < 5; i = i + 1)
        acq_cfg[i] <= 8'h00;
      cont_mode        <= 1'b0;
      bypass           <= 1'b0;
      aw_addr          <= 8'h00;
      aw_held          <= 1'b0;
      w_data           <= 32'h00000000;
      w_strb           <= 4'h0;
      w_held           <= 1'b0;
      s_axi_bvalid     <= 1'b0;
      s_axi_bresp      <= `ACS_RESP_OKAY;
      gain_stage_reset <= 1'b0;
      swrst_req        <= 1'b0;
      start_req        <= 1'b0;
    end
    else
    begin
      gain_stage_reset <= wr_acq && w_strb[0];
      swrst_req <= wr_ctrl && w_strb[0] && w_data[`ACS_CTRL_SWRST];
      start_req <= wr_ctrl && w_strb[0] && w_data[`ACS_CTRL_START];
      if (s_axi_awvalid && !aw_held)
      begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `ACS_RESP_OKAY;
        if (wr_acq && w_strb[0])
          acq_cfg[acq_idx] <= w_data[7:0];
        else if (wr_ctrl && w_strb[0])
        begin
          cont_mode <= w_data[`ACS_CTRL_CONT];
          bypass    <= w_data[`ACS_CTRL_BYPASS];
        end
        else if (!wr_acq && !wr_ctrl)
          s_axi_bresp <= `ACS_RESP_SLVERR;
      end
    end
  end

  // ***************************************************
  // Conversion sequencing
  // ***************************************************
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      converting             <= 1'b0;
      conv_count             <= 15'h0000;
      conversion_done        <= 1'b0;
      result                 <= {RES_W{1'b0}};
      gain_stage_bias_select <= `ACS_BIAS_NOMINAL;
      converter_bias_select  <= `ACS_BIAS_NOMINAL;
    end
    else
    begin
      gain_stage_bias_select <= acq_cfg[0][`ACS_ACQ1_GBIAS_LSB +: 2];
      converter_bias_select  <= acq_cfg[1][1:0];
      conversion_done <= 1'b0;
      if (!active || (gain_stage_reset && !bypass))
        converting <= 1'b0;
      else if (start_req && !converting)
      begin
        converting <= 1'b1;
        conv_count <= 15'h0001;
      end
      else if (converting)
      begin
        if (conv_count == conv_len - 15'h0001)
        begin
          conversion_done <= 1'b1;
          result <= sample_data >> (RES_W[4:0] - eff_res);
          conv_count <= 15'h0000;
          converting <= cont_mode;
        end
        else
          conv_count <= conv_count + 15'h0001;
      end
    end
  end

  // ***************************************************
  // Register reads
  // ***************************************************
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `ACS_RESP_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else if (s_axi_arvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `ACS_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      if (s_axi_araddr == `ACS_ADDR_CTRL)
        s_axi_rdata <= {27'h0, bypass, 2'h0, cont_mode, 1'b0};
      else if (s_axi_araddr >= `ACS_ADDR_ACQ1 &&
               s_axi_araddr <= `ACS_ADDR_ACQ5 &&
               s_axi_araddr[1:0] == 2'h0)
        s_axi_rdata <= {24'h0, acq_cfg[s_axi_araddr[4:2] - 3'h1]};
      else if (s_axi_araddr == `ACS_ADDR_STATUS)
        s_axi_rdata <= {19'h0, resolution, 5'h0, converting, pwr_state};
      else if (s_axi_araddr == `ACS_ADDR_RESULT)
        s_axi_rdata <= {{(32-RES_W){1'b0}}, result};
      else if (s_axi_araddr == `ACS_ADDR_LEN)
        s_axi_rdata <= {17'h0, conv_len};
      else
        s_axi_rresp <= `ACS_RESP_SLVERR;
    end
  end
endmodule

/* File: bench/acs_assertions.sv */
// Port checks for the conversion sequencer
`timescale 1ns/1ps
`include "acs_defines.vh"
module acs_checker (
  input wire       clock,
  input wire       arst_n,
  input wire [7:0] s_axi_awaddr,
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready,
  input wire       gain_stage_reset,
  input wire       conversion_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence acq_hit;
    s_axi_awaddr >= `ACS_ADDR_ACQ1 && s_axi_awaddr <= `ACS_ADDR_ACQ5;
  endsequence
  done_pulse_a: assert property (conversion_done |=> !conversion_done)
    else $error("done pulse too long");
  done_gap_a: assert property (
    conversion_done |=> !conversion_done [*8])
    else $error("conversion too short");
  gsr_pulse_a: assert property (
    gain_stage_reset |=> !gain_stage_reset)
    else $error("gain reset pulse too long");
  acq_reset_a: assert property (
    wr_both ##0 acq_hit |-> ##[1:3] gain_stage_reset)
    else $error("no gain reset after config write");
  wr_answer_a: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  wr_retire_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  rd_retire_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not retired");
endmodule
bind acs_sequencer acs_checker u_acs_checker (
  .clock            (clock),
  .arst_n           (arst_n),
  .s_axi_awaddr     (s_axi_awaddr),
  .s_axi_awvalid    (s_axi_awvalid),
  .s_axi_awready    (s_axi_awready),
  .s_axi_wvalid     (s_axi_wvalid),
  .s_axi_wready     (s_axi_wready),
  .s_axi_bvalid     (s_axi_bvalid),
  .s_axi_bready     (s_axi_bready),
  .s_axi_arvalid    (s_axi_arvalid),
  .s_axi_arready    (s_axi_arready),
  .s_axi_rvalid     (s_axi_rvalid),
  .s_axi_rready     (s_axi_rready),
  .gain_stage_reset (gain_stage_reset),
  .conversion_done  (conversion_done)
);

/* File: bench/acs_host_model.sv */
// Far side: converter word source and done counter
`timescale 1ns/1ps
module acs_host_model (
  input  wire        clock,
  input  wire        arst_n,
  input  wire [15:0] word,
  input  wire        conversion_done,
  output reg  [15:0] sample_data,
  output reg  [15:0] done_count
);
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sample_data <= 16'h0;
      done_count  <= 16'h0;
    end
    else
    begin
      sample_data <= word;
      if (conversion_done)
        done_count <= done_count + 16'h1;
    end
  end
endmodule

/* File: bench/tb.sv */
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`include "acs_defines.vh"
module tb;
  reg         clock, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, rd;
  reg  [3:0]  s_axi_wstrb;
  reg  [15:0] word;
  reg  [1:0]  b;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, gain_stage_reset, conversion_done;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [1:0]  gain_stage_bias_select, converter_bias_select;
  wire [31:0] s_axi_rdata;
  wire [15:0] sample_data, done_count;
  integer     mismatches, checked, cycles, seed, i, n, t, dc;
  acs_sequencer #(.STARTUP_CYCLES(50), .WAKE_CYCLES(20)) u_acs_sequencer (.*);
  acs_host_model u_acs_host_model (.*);
  always #2.5 clock = ~clock;
  task close_out;
    begin
      if (mismatches == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles == 60000)
    begin
      mismatches = mismatches + 1;
      close_out;
    end
  end
  task cmp(input [63:0] nm, input [31:0] e, input [31:0] s);
    begin
      checked = checked + 1;
      if (s !== e)
      begin
        mismatches = mismatches + 1;
        $display("mismatch %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  function integer clen(input integer c, input integer e);
    clen = (1 << e) * ((8 << c) + 1) + 1;
  endfunction
  function [15:0] exp_res(input [15:0] w, input integer r);
    exp_res = w >> (16 - ((r > 16) ? 16 : r));
  endfunction
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg aw, w;
    begin
      aw = 0;
      w = 0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(aw && w))
      begin
        @(posedge clock);
        if (!aw && s_axi_awready === 1'b1)
        begin
          aw = 1;
          s_axi_awvalid <= 0;
        end
        if (!w && s_axi_wready === 1'b1)
        begin
          w = 1;
          s_axi_wvalid <= 0;
        end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge clock);
      s_axi_bready <= 0;
      cmp("bresp", er, s_axi_bresp);
    end
  endtask
  task rd_reg(input [7:0] a, input [1:0] er);
    begin
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      @(posedge clock);
      while (s_axi_arready !== 1'b1) @(posedge clock);
      s_axi_arvalid <= 0;
      @(posedge clock);
      while (s_axi_rvalid !== 1'b1) @(posedge clock);
      s_axi_rready <= 0;
      rd = s_axi_rdata;
      cmp("rresp", er, s_axi_rresp);
    end
  endtask
  initial
  begin
    clock = 0; arst_n = 0; s_axi_awvalid = 0; s_axi_wvalid = 0;
    s_axi_bready = 0; s_axi_arvalid = 0; s_axi_rready = 0;
    s_axi_awaddr = 0; s_axi_araddr = 0; s_axi_wdata = 0;
    s_axi_wstrb = 4'hf; word = 0; seed = 32'h277f6bd4;
    mismatches = 0; checked = 0; cycles = 0;
    repeat (4) @(posedge clock);
    cmp("gbias", `ACS_BIAS_NOMINAL, gain_stage_bias_select);
    arst_n <= 1;
    rd_reg(`ACS_ADDR_STATUS, `ACS_RESP_OKAY);
    cmp("awake", 0, rd[1:0] == `ACS_PWR_ACTIVE);
    repeat (80) @(posedge clock);
    rd_reg(`ACS_ADDR_STATUS, `ACS_RESP_OKAY);
    cmp("pwr", `ACS_PWR_ACTIVE, rd[1:0]);
    wr(8'h40, 0, `ACS_RESP_SLVERR);
    rd_reg(8'h40, `ACS_RESP_SLVERR);
    for (i = 0; i < 8; i = i + 1)
    begin
      n = (i == 7) ? 0 : ($random(seed) & 3);
      b = $random(seed);
      wr(`ACS_ADDR_ACQ1, {25'h0, b, n[1:0], i[2:0]}, 0);
      @(posedge clock);
      cmp("gbias", b, gain_stage_bias_select);
      wr(`ACS_ADDR_ACQ1 + 8'h4, {30'h0, ~b}, 0);
      @(posedge clock);
      cmp("cbias", {30'h0, ~b}, converter_bias_select);
      rd_reg(`ACS_ADDR_STATUS, 0);
      if (2 * (i + 3) + n <= 16)
        cmp("res", 2 * (i + 3) + n, rd[12:8]);
      if (i != 3)
        repeat (8 << i) @(posedge clock);
      word <= $random(seed);
      wr(`ACS_ADDR_CTRL, (i == 3) ? 32'h13 : 32'h3, 0);
      while (conversion_done !== 1'b1) @(posedge clock);
      t = 0;
      do
      begin
        @(posedge clock);
        t = t + 1;
      end while (conversion_done !== 1'b1);
      cmp("len", clen(i, n), t);
      wr(`ACS_ADDR_CTRL, 0, 0);
      rd_reg(`ACS_ADDR_RESULT, 0);
      cmp("result", exp_res(word, 2 * (i + 3) + n), rd[15:0]);
    end
    repeat (clen(7, 0)) @(posedge clock);
    dc = done_count;
    wr(`ACS_ADDR_CTRL, 32'h1, 0);
    repeat (3 * clen(7, 0)) @(posedge clock);
    cmp("dones", dc + 1, done_count);
    wr(`ACS_ADDR_CTRL, 32'h8, 0);
    rd_reg(`ACS_ADDR_STATUS, 0);
    cmp("swrst", `ACS_PWR_STARTUP, rd[1:0]);
    repeat (60) @(posedge clock);
    rd_reg(`ACS_ADDR_STATUS, 0);
    cmp("restart", `ACS_PWR_ACTIVE, rd[1:0]);
    wr(`ACS_ADDR_CTRL, 32'h4, 0);
    rd_reg(`ACS_ADDR_STATUS, 0);
    cmp("sleep", `ACS_PWR_SLEEP, rd[1:0]);
    repeat (80) @(posedge clock);
    rd_reg(`ACS_ADDR_STATUS, 0);
    cmp("rewake", `ACS_PWR_ACTIVE, rd[1:0]);
    close_out;
  end
endmodule
